// ### rtl/pai_regs.svh
`ifndef PAI_REGS_SVH
`define PAI_REGS_SVH

`define PAI_OFF_DATA      8'h00
`define PAI_OFF_DIR       8'h04
`define PAI_OFF_PULL      8'h08
`define PAI_OFF_SLEW      8'h0c
`define PAI_OFF_DRIVE     8'h10
`define PAI_OFF_SC        8'h14
`define PAI_OFF_PINSEL    8'h18
`define PAI_OFF_POL       8'h1c
`define PAI_OFF_EVSTAT    8'h20
`define PAI_OFF_EVCLR     8'h24
`define PAI_OFF_EVEN      8'h28

`define PAI_SC_FLAG_BIT   3
`define PAI_SC_ACK_BIT    2
`define PAI_SC_IE_BIT     1
`define PAI_SC_MODE_BIT   0

`define PAI_EV_FLAG_BIT   0

`define PAI_RST_BYTE      8'h00
`define PAI_RST_WORD      32'h0000_0000

`endif

// ### rtl/pai_pkg.sv
package pai_pkg;
	typedef logic [7:0]  pai_byte_t;
	typedef logic [31:0] pai_word_t;
	typedef enum logic [1:0] {
		PAI_MODE_EDGE      = 2'b01,
		PAI_MODE_EDGE_LVL  = 2'b10
	} pai_mode_e;
endpackage

// ### rtl/pai_port.sv
// The APB register port and the register offsets were chosen for this implementation.
`include "pai_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pai_port
	import pai_pkg::*;
#(
	parameter int WIDTH = 8
)(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire pai_pkg::pai_word_t pwdata,
	output var  pai_pkg::pai_word_t prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// Pins
	input  wire logic [WIDTH-1:0]  pin_in,
	output var  logic [WIDTH-1:0]  pin_out,
	output var  logic [WIDTH-1:0]  pin_oe_n,
	output var  logic [WIDTH-1:0]  pull_on,
	output var  logic [WIDTH-1:0]  pull_down,
	output var  logic [WIDTH-1:0]  slew_limit,
	output var  logic [WIDTH-1:0]  drive_high,
	// Interrupts
	output var  logic              port_irq,
	output var  logic              sys_irq
);

	logic [WIDTH-1:0] pin_data_latch_q;
	logic [WIDTH-1:0] direction_bits_q;
	logic [WIDTH-1:0] pull_enable_bits_q;
	logic [WIDTH-1:0] slew_enable_bits_q;
	logic [WIDTH-1:0] drive_strength_bits_q;
	logic [WIDTH-1:0] irq_pin_select_q;
	logic [WIDTH-1:0] polarity_select_q;
	logic             irq_flag_q;
	logic             irq_flag_d;
	logic             irq_enable_q;
	logic             detect_mode_q;
	logic [WIDTH-1:0] pin_prev_q;
	logic             ev_stat_q;
	logic             ev_stat_d;
	logic             ev_en_q;
	pai_word_t        prdata_d;

	function automatic logic [WIDTH-1:0] asserted_of(
		input logic [WIDTH-1:0] lvl,
		input logic [WIDTH-1:0] pol,
		input logic [WIDTH-1:0] sel
	);
		asserted_of = ~(lvl ^ pol) & sel;
	endfunction

	function automatic pai_word_t zext(input logic [WIDTH-1:0] v);
		zext = pai_word_t'(v);
	endfunction

	// Bus decode
	wire wr_en  = psel & penable & pwrite;
	wire rd_en  = psel & penable & ~pwrite;
	wire sel_data   = (paddr == `PAI_OFF_DATA);
	wire sel_dir    = (paddr == `PAI_OFF_DIR);
	wire sel_pull   = (paddr == `PAI_OFF_PULL);
	wire sel_slew   = (paddr == `PAI_OFF_SLEW);
	wire sel_drive  = (paddr == `PAI_OFF_DRIVE);
	wire sel_sc     = (paddr == `PAI_OFF_SC);
	wire sel_pinsel = (paddr == `PAI_OFF_PINSEL);
	wire sel_pol    = (paddr == `PAI_OFF_POL);
	wire sel_evstat = (paddr == `PAI_OFF_EVSTAT);
	wire sel_evclr  = (paddr == `PAI_OFF_EVCLR);
	wire sel_even   = (paddr == `PAI_OFF_EVEN);
	wire sel_any    = sel_data | sel_dir | sel_pull | sel_slew | sel_drive
		| sel_sc | sel_pinsel | sel_pol | sel_evstat | sel_evclr | sel_even;

	// Pin-side decode
	wire [WIDTH-1:0] is_out     = direction_bits_q;
	wire [WIDTH-1:0] data_view  =
		(is_out & pin_data_latch_q) | (~is_out & pin_in);
	wire [WIDTH-1:0] asserted_now =
		asserted_of(pin_in, polarity_select_q, irq_pin_select_q);
	wire [WIDTH-1:0] asserted_prev =
		asserted_of(pin_prev_q, polarity_select_q, irq_pin_select_q);
	wire [WIDTH-1:0] edge_hit = asserted_now & ~asserted_prev;
	wire             any_level = |asserted_now;
	pai_mode_e       mode;
	assign mode = detect_mode_q ? PAI_MODE_EDGE_LVL : PAI_MODE_EDGE;

	logic set_flag;
	logic ack_ok;
	always_comb
	begin
		unique case (mode)
			PAI_MODE_EDGE:
			begin
				set_flag = |edge_hit;
				ack_ok   = 1'b1;
			end
			PAI_MODE_EDGE_LVL:
			begin
				set_flag = (|edge_hit) | any_level;
				ack_ok   = ~any_level;
			end
			default:
			begin
				set_flag = 1'b0;
				ack_ok   = 1'b0;
			end
		endcase
	end

	wire ack_wr = wr_en & sel_sc & pwdata[`PAI_SC_ACK_BIT];
	// Set wins over an acknowledge in the same cycle
	assign irq_flag_d = set_flag | (irq_flag_q & ~(ack_wr & ack_ok));
	wire flag_rise  = set_flag & ~irq_flag_q;
	wire ev_clr_wr  = wr_en & sel_evclr & pwdata[`PAI_EV_FLAG_BIT];
	assign ev_stat_d = flag_rise | (ev_stat_q & ~ev_clr_wr);

	pai_byte_t sc_view;
	assign sc_view = {4'h0, irq_flag_q, 1'b0, irq_enable_q,
		detect_mode_q};

	always_comb
	begin
		prdata_d = `PAI_RST_WORD;
		if (sel_data)
			prdata_d = zext(data_view);
		else if (sel_dir)
			prdata_d = zext(direction_bits_q);
		else if (sel_pull)
			prdata_d = zext(pull_enable_bits_q);
		else if (sel_slew)
			prdata_d = zext(slew_enable_bits_q);
		else if (sel_drive)
			prdata_d = zext(drive_strength_bits_q);
		else if (sel_sc)
			prdata_d = pai_word_t'(sc_view);
		else if (sel_pinsel)
			prdata_d = zext(irq_pin_select_q);
		else if (sel_pol)
			prdata_d = zext(polarity_select_q);
		else if (sel_evstat)
			prdata_d = pai_word_t'(ev_stat_q);
		else if (sel_even)
			prdata_d = pai_word_t'(ev_en_q);
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_data_latch_q      <= '0;
			direction_bits_q      <= '0;
			pull_enable_bits_q    <= '0;
			slew_enable_bits_q    <= '0;
			drive_strength_bits_q <= '0;
			irq_pin_select_q      <= '0;
			polarity_select_q     <= '0;
			irq_enable_q          <= 1'b0;
			detect_mode_q         <= 1'b0;
			ev_en_q               <= 1'b0;
		end
		else if (wr_en)
		begin
			if (sel_data)
				pin_data_latch_q <= pwdata[WIDTH-1:0];
			if (sel_dir)
				direction_bits_q <= pwdata[WIDTH-1:0];
			if (sel_pull)
				pull_enable_bits_q <= pwdata[WIDTH-1:0];
			if (sel_slew)
				slew_enable_bits_q <= pwdata[WIDTH-1:0];
			if (sel_drive)
				drive_strength_bits_q <= pwdata[WIDTH-1:0];
			if (sel_pinsel)
				irq_pin_select_q <= pwdata[WIDTH-1:0];
			if (sel_pol)
				polarity_select_q <= pwdata[WIDTH-1:0];
			if (sel_sc)
			begin
				irq_enable_q  <= pwdata[`PAI_SC_IE_BIT];
				detect_mode_q <= pwdata[`PAI_SC_MODE_BIT];
			end
			if (sel_even)
				ev_en_q <= pwdata[`PAI_EV_FLAG_BIT];
		end
	end

	// Detection state and flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_prev_q <= '0;
			irq_flag_q <= 1'b0;
			ev_stat_q  <= 1'b0;
		end
		else
		begin
			pin_prev_q <= pin_in;
			irq_flag_q <= irq_flag_d;
			ev_stat_q  <= ev_stat_d;
		end
	end

	// Registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata     <= `PAI_RST_WORD;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			pin_out    <= '0;
			pin_oe_n   <= '1;
			pull_on    <= '0;
			pull_down  <= '0;
			slew_limit <= '0;
			drive_high <= '0;
			port_irq   <= 1'b0;
			sys_irq    <= 1'b0;
		end
		else
		begin
			pready     <= psel & ~penable;
			pslverr    <= psel & ~penable & ~sel_any;
			prdata     <= (psel & ~penable & ~pwrite) ? prdata_d
				: `PAI_RST_WORD;
			pin_out    <= pin_data_latch_q & is_out;
			pin_oe_n   <= ~is_out;
			pull_on    <= pull_enable_bits_q & ~is_out;
			pull_down  <= pull_enable_bits_q & ~is_out
				& irq_pin_select_q & polarity_select_q;
			slew_limit <= slew_enable_bits_q & is_out;
			drive_high <= drive_strength_bits_q & is_out;
			port_irq   <= irq_flag_d & irq_enable_q;
			sys_irq    <= ev_stat_d & ev_en_q;
		end
	end

endmodule

`default_nettype wire

// ### dv/pai_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pai_port_chk
	import pai_pkg::*;
(
	// Clock, reset and bus
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire pai_pkg::pai_word_t prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	// Pin controls and request
	input wire logic [7:0]         pin_out,
	input wire logic [7:0]         pin_oe_n,
	input wire logic [7:0]         pull_on,
	input wire logic [7:0]         pull_down,
	input wire logic [7:0]         slew_limit,
	input wire logic [7:0]         drive_high,
	input wire logic               port_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_data = pready && !pwrite && paddr == 8'h00;
	wire rd_sc = pready && !pwrite && paddr == 8'h14;
	a_in_no_out: assert property ((pin_out & pin_oe_n) == 8'h00)
		else $error("input pin shows latch value");
	a_read_latch: assert property (rd_data |->
		((prdata[7:0] ^ pin_out) & ~pin_oe_n) == 8'h00)
		else $error("output pin read not from latch");
	a_pull_in_only: assert property ((pull_on & ~pin_oe_n) == 8'h00)
		else $error("pull on a driven pin");
	a_down_needs_pull: assert property ((pull_down & ~pull_on) == 8'h00)
		else $error("pull-down without pull");
	a_slew_out_only: assert property ((slew_limit & pin_oe_n) == 8'h00)
		else $error("slew limit on input");
	a_drive_out_only: assert property ((drive_high & pin_oe_n) == 8'h00)
		else $error("high drive on input");
	a_ack_reads_zero: assert property (rd_sc |-> prdata[2] == 1'b0)
		else $error("ack bit read as one");
	a_irq_follows: assert property (rd_sc && prdata[3:1] == 3'b101
		|-> ##[0:1] port_irq)
		else $error("flag and enable without request");
	a_reset_inputs: assert property ($rose(presetn)
		|-> pin_oe_n == 8'hff && pull_on == 8'h00)
		else $error("pins not idle after reset");
	cover property (port_irq);
	cover property (pslverr);
	cover property (pull_down != 8'h00);
endmodule
bind pai_port pai_port_chk chk_i (.*);
`default_nettype wire

// ### dv/pai_board.sv
`timescale 1ns/1ps
`default_nettype none
module pai_board (
	// Device side
	input  wire logic       pclk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [7:0] pull_on,
	input  wire logic [7:0] pull_down,
	// Board drivers
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	// Level seen by the device
	output var  logic [7:0] pin_in
);
	initial pin_in = 8'h00;
	// A floating pin flips every cycle so it never reads as settled
	always @(posedge pclk)
		for (int i = 0; i < 8; i++)
			pin_in[i] <= !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i]
				: pull_on[i] ? !pull_down[i] : !pin_in[i];
endmodule
`default_nettype wire

// ### dv/port_a_pin_control_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_a_pin_control_irq_tb;
	import pai_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, port_irq, sys_irq, err;
	logic [7:0] paddr = 8'h00, ext_val = 8'h00, ext_en = 8'h00, pin_in;
	logic [7:0] pin_out, pin_oe_n, pull_on, pull_down, slew_limit, drive_high;
	pai_word_t pwdata = 32'h0, prdata, rdat;
	int miscompares = 0, total_checks = 0;
	always #2.5 pclk = ~pclk;
	pai_port dut (.*);
	pai_board board (.*);
	task automatic end_sim;
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input pai_word_t e, input pai_word_t g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input pai_word_t d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for ready at a rising edge; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string n, input logic [7:0] a, input pai_word_t e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, rdat);
	endtask
	task automatic gap;
		repeat (3) @(posedge pclk);
		#1;
	endtask
	initial
	begin
		#20000;
		miscompares++;
		end_sim();
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("oe", 8'hff, pin_oe_n);
		for (int a = 4; a <= 28; a += 4)
			rd("reset", a[7:0], 32'h0);
		ext_val <= 8'h5a;
		ext_en <= 8'he0;
		xfer(1'b1, 8'h00, 32'h3c);
		xfer(1'b1, 8'h04, 32'h0f);
		xfer(1'b1, 8'h08, 32'hff);
		xfer(1'b1, 8'h0c, 32'hff);
		xfer(1'b1, 8'h10, 32'hff);
		xfer(1'b1, 8'h1c, 32'h10);
		xfer(1'b1, 8'h18, 32'h50);
		gap();
		chk("oe", 8'hf0, pin_oe_n);
		chk("out", 8'h0c, pin_out);
		chk("pull", 8'hf0, pull_on);
		chk("down", 8'h10, pull_down);
		chk("slew", 8'h0f, slew_limit);
		chk("drive", 8'h0f, drive_high);
		rd("data", 8'h00, 32'h4c);
		xfer(1'b1, 8'h28, 32'h1);
		xfer(1'b1, 8'h14, 32'h06);
		rd("sc", 8'h14, 32'h02);
		@(posedge pclk);
		ext_val <= 8'h1a;
		gap();
		rd("sc", 8'h14, 32'h0a);
		chk("irq", 1'b1, port_irq);
		chk("sys", 1'b1, sys_irq);
		xfer(1'b1, 8'h24, 32'h1);
		xfer(1'b1, 8'h14, 32'h06);
		gap();
		chk("sys", 1'b0, sys_irq);
		rd("sc", 8'h14, 32'h02);
		xfer(1'b1, 8'h14, 32'h03);
		gap();
		rd("sc", 8'h14, 32'h0b);
		xfer(1'b1, 8'h14, 32'h07);
		rd("sc", 8'h14, 32'h0b);
		@(posedge pclk);
		ext_val <= 8'h5a;
		xfer(1'b1, 8'h14, 32'h07);
		rd("sc", 8'h14, 32'h03);
		xfer(1'b1, 8'h14, 32'h08);
		gap();
		rd("sc", 8'h14, 32'h00);
		chk("irq", 1'b0, port_irq);
		rd("unmapped", 8'h40, 32'h0);
		chk("slverr", 1'b1, err);
		end_sim();
	end
endmodule
`default_nettype wire
